// ### verilog/gsf_defines.svh
// Purpose: Addresses, field positions, reset values and timing counts of the general status flag block.
// Assumes: A 25 MHz system clock.
// Notes: Definitions only.
`ifndef GSF_DEFINES_SVH
`define GSF_DEFINES_SVH

// ==========================================================================
// Register addresses
`define GSF_ADDR_STATUS 8'h00
`define GSF_ADDR_CONFIG 8'h04
`define GSF_ADDR_IRQ_STATUS 8'h08
`define GSF_ADDR_IRQ_MASK 8'h0C
`define GSF_ADDR_MODE 8'h10

// ==========================================================================
// Field positions
`define GSF_CFG_LATCH_BIT 0
`define GSF_CFG_INPUT_BIT 1
`define GSF_MODE_AUTO_BIT 0
`define GSF_MODE_DIS_BIT 1

// ==========================================================================
// Reset values
`define GSF_CONFIG_RESET 2'h0
`define GSF_IRQ_MASK_RESET 4'h0

// ==========================================================================
// Timing
`define GSF_CLK_PERIOD_NS 40
`define GSF_T_INNER_STAR_CLAMP_FLAG_NS 4000
`define GSF_T_TRANSMIT_ENABLE_CLAMP_FLAG_NS 4000
`define GSF_T_COLL_NS 2000
`define GSF_T_IO_SUPPLY_UNDERVOLTAGE_FLAG_NS 100000
`define GSF_CYCLES(t) ((t + `GSF_CLK_PERIOD_NS - 1) / `GSF_CLK_PERIOD_NS)

`endif

// ### verilog/gsf_pkg.sv
// Purpose: Types of the general status flag block.
// Assumes: Constants live in gsf_defines.svh.
// Notes: The status word is twelve bits with odd parity in bit 0.
package gsf_pkg;

    typedef struct packed {
        logic localWakeFlag;
        logic innerStarWakeFlag;
        logic guardianPinFeedback;
        logic batteryUndervoltageFlag;
        logic coreSupplyUndervoltageFlag;
        logic ioSupplyUndervoltageFlag;
        logic tempWarnFlag;
        logic tempHighFlag;
        logic innerStarClampFlag;
        logic transmitEnableClampFlag;
        logic innerStarCollisionFlag;
        logic parity;
    } gsf_status_t;

    typedef struct packed {
        logic clampInterrupt;
        logic tempInterrupt;
        logic undervoltageInterrupt;
        logic wakeInterrupt;
    } gsf_irq_t;

    typedef enum logic [1:0] {
        STAR_NORMAL_MODE,
        STAR_STANDBY_MODE,
        STAR_SLEEP_MODE,
        STAR_OTHER_MODE
    } gsf_mode_e;

    typedef enum logic {
        CTRL_HOST,
        CTRL_AUTONOMOUS
    } gsf_ctrl_e;

    typedef struct packed {
        gsf_status_t flags;
        logic bitLatching;
        logic innerStarInput;
        gsf_irq_t irqStatus;
        gsf_irq_t irqMask;
        logic [11:0] cntTrxdClamp;
        logic [11:0] cntColl;
        logic [11:0] cntTxenClamp;
        logic [11:0] cntVio;
        logic liveTrxdClamp;
        logic liveTxenClamp;
        logic liveTempWarn;
        logic liveTempHigh;
        logic [2:0] prevUv;
        gsf_ctrl_e ctrl;
        gsf_mode_e prevMode;
        logic [15:0] rdata;
        logic irq;
        logic innerStarDriverEnable;
        logic innerStarDataIgnore;
        logic transmitInputsIgnore;
        logic forceBranchDisabled;
        logic digitalInputsDisabled;
    } gsf_state_t;

endpackage

// ### verilog/gsf_general_status_flag_logic.sv
// Purpose: Set, clear and latching logic of the general status flags, with interrupt and register port.
// Assumes: Detector inputs are already filtered levels; wake inputs are one-cycle pulses; all synchronous.
// Notes: A status read clears wake and collision flags and releases latched flags in one edge.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "gsf_defines.svh"

// Operation
// - Local wake event sets the local wake flag and a wake interrupt.
// - Inner-star wake event sets the inner-star wake flag and a wake interrupt.
// - Status read or leaving normal for standby/sleep clears both wake flags.
// - Guardian feedback bit mirrors the guardian enable pin level.
// - Any supply undervoltage sets its flag and an undervoltage interrupt.
// - With latching on, a set flag holds until read, then follows live.
// - With latching off, undervoltage, temperature and clamp flags show the live condition.
// - During IO undervoltage, inputs are disabled and host commands refused.
// - IO undervoltage past its timeout sets autonomous mode.
// - Temperature warning sets its flag and a temperature interrupt.
// - High temperature sets flag, disables link driver, disables branches, interrupts.
// - Live temperature flags clear only when cool and with no activity.
// - Link input line low past clamp time sets clamp, disables and ignores link.
// - Live link clamp holds while a line is low, clears when both high.
// - Transmit enable low past clamp time sets clamp, ignores inputs, interrupts.
// - Live transmit-enable clamp holds while low, clears once high.
// - Bit 0 makes the whole status word odd parity.
// - Both link lines low past collision time set collision flag; read clears it.
module gsf_general_status_flag_logic
    import gsf_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [15:0] rdata,
    input wire logic localWakeEvent,
    input wire logic innerStarWakeEvent,
    input wire logic guardianEnablePin,
    input wire logic batteryUvDetect,
    input wire logic coreSupplyUvDetect,
    input wire logic ioSupplyUvDetect,
    input wire logic tempWarnDetect,
    input wire logic tempHighDetect,
    input wire logic linkActivity,
    input wire logic innerStarLineA,
    input wire logic innerStarLineB,
    input wire logic controllerTransmitEnable,
    input wire gsf_mode_e starMode,
    output logic irq,
    output logic innerStarDriverEnable,
    output logic innerStarDataIgnore,
    output logic transmitInputsIgnore,
    output logic forceBranchDisabled,
    output logic digitalInputsDisabled,
    output logic autonomousModeFlag
);

    // ==========================================================================
    // Timing counts
    localparam logic [11:0] INNER_STAR_CLAMP_FLAG_CYC = 12'(`GSF_CYCLES(`GSF_T_INNER_STAR_CLAMP_FLAG_NS));
    localparam logic [11:0] TRANSMIT_ENABLE_CLAMP_FLAG_CYC = 12'(`GSF_CYCLES(`GSF_T_TRANSMIT_ENABLE_CLAMP_FLAG_NS));
    localparam logic [11:0] COLL_CYC = 12'(`GSF_CYCLES(`GSF_T_COLL_NS));
    localparam logic [11:0] IO_SUPPLY_UNDERVOLTAGE_FLAG_CYC = 12'(`GSF_CYCLES(`GSF_T_IO_SUPPLY_UNDERVOLTAGE_FLAG_NS));

    gsf_state_t st;
    gsf_state_t next_st;

    // Latched flags hold their set value until a read; live flags follow the condition.
    function automatic logic latchFlag(input logic flag, input logic live, input logic latch, input logic clr);
        latchFlag = latch ? (live | (flag & ~clr)) : live;
    endfunction

    // ==========================================================================
    // Next state
    always_comb begin
        logic hostOk;
        logic wrEn;
        logic rdEn;
        logic statusRead;
        logic leaveNormal;
        logic trxdLow;
        logic bothLow;
        logic collSet;
        logic [2:0] uvNow;
        gsf_irq_t events;
        gsf_status_t f;
        hostOk = 1'b0;
        wrEn = 1'b0;
        rdEn = 1'b0;
        statusRead = 1'b0;
        leaveNormal = 1'b0;
        trxdLow = 1'b0;
        bothLow = 1'b0;
        collSet = 1'b0;
        uvNow = 3'h0;
        events = '0;
        f = st.flags;
        next_st = st;

        // Host commands are refused while the IO supply is low.
        hostOk = ~ioSupplyUvDetect;
        wrEn = wr & hostOk;
        rdEn = rd & hostOk;
        statusRead = rdEn && (addr == `GSF_ADDR_STATUS);
        leaveNormal = (st.prevMode == STAR_NORMAL_MODE) &&
                      ((starMode == STAR_STANDBY_MODE) || (starMode == STAR_SLEEP_MODE));
        next_st.prevMode = starMode;

        // ======================================================================
        // Inner-star clamp and collision timing
        trxdLow = ~innerStarLineA | ~innerStarLineB;
        bothLow = ~innerStarLineA & ~innerStarLineB;
        if (st.innerStarInput && trxdLow) begin
            if (st.cntTrxdClamp != INNER_STAR_CLAMP_FLAG_CYC) begin
                next_st.cntTrxdClamp = st.cntTrxdClamp + 12'h001;
            end
        end else begin
            next_st.cntTrxdClamp = 12'h000;
        end
        if (st.innerStarInput && trxdLow && (st.cntTrxdClamp == INNER_STAR_CLAMP_FLAG_CYC)) begin
            next_st.liveTrxdClamp = 1'b1;
        end else if (innerStarLineA && innerStarLineB) begin
            next_st.liveTrxdClamp = 1'b0;
        end
        if (bothLow) begin
            if (st.cntColl != COLL_CYC) begin
                next_st.cntColl = st.cntColl + 12'h001;
            end
        end else begin
            next_st.cntColl = 12'h000;
        end
        collSet = bothLow && (st.cntColl == COLL_CYC - 12'h001);

        // ======================================================================
        // Transmit-enable clamp timing
        if (!controllerTransmitEnable) begin
            if (st.cntTxenClamp != TRANSMIT_ENABLE_CLAMP_FLAG_CYC) begin
                next_st.cntTxenClamp = st.cntTxenClamp + 12'h001;
            end
        end else begin
            next_st.cntTxenClamp = 12'h000;
        end
        if (!controllerTransmitEnable && (st.cntTxenClamp == TRANSMIT_ENABLE_CLAMP_FLAG_CYC)) begin
            next_st.liveTxenClamp = 1'b1;
        end else if (controllerTransmitEnable) begin
            next_st.liveTxenClamp = 1'b0;
        end

        // ======================================================================
        // Temperature live state: a hot die or any traffic keeps it set.
        next_st.liveTempWarn = tempWarnDetect | (st.liveTempWarn & linkActivity);
        next_st.liveTempHigh = tempHighDetect | (st.liveTempHigh & linkActivity);

        // ======================================================================
        // IO undervoltage timeout and control ownership
        if (ioSupplyUvDetect) begin
            if (st.cntVio != IO_SUPPLY_UNDERVOLTAGE_FLAG_CYC) begin
                next_st.cntVio = st.cntVio + 12'h001;
            end
        end else begin
            next_st.cntVio = 12'h000;
        end
        case (st.ctrl)
            CTRL_HOST: begin
                if (ioSupplyUvDetect && (st.cntVio == IO_SUPPLY_UNDERVOLTAGE_FLAG_CYC)) begin
                    next_st.ctrl = CTRL_AUTONOMOUS;
                end
            end
            CTRL_AUTONOMOUS: begin
                // Only the host can take control back, and only with the IO supply good.
                if (wrEn && (addr == `GSF_ADDR_MODE) && wdata[`GSF_MODE_AUTO_BIT]) begin
                    next_st.ctrl = CTRL_HOST;
                end
            end
            default: begin
                next_st.ctrl = CTRL_HOST;
            end
        endcase

        // ======================================================================
        // Status flags
        uvNow = {batteryUvDetect, coreSupplyUvDetect, ioSupplyUvDetect};
        next_st.prevUv = uvNow;
        f.localWakeFlag = localWakeEvent | (st.flags.localWakeFlag & ~statusRead & ~leaveNormal);
        f.innerStarWakeFlag = innerStarWakeEvent |
                              (st.flags.innerStarWakeFlag & ~statusRead & ~leaveNormal);
        f.guardianPinFeedback = guardianEnablePin;
        f.batteryUndervoltageFlag = latchFlag(st.flags.batteryUndervoltageFlag, batteryUvDetect,
                                              st.bitLatching, statusRead);
        f.coreSupplyUndervoltageFlag = latchFlag(st.flags.coreSupplyUndervoltageFlag, coreSupplyUvDetect,
                                                 st.bitLatching, statusRead);
        f.ioSupplyUndervoltageFlag = latchFlag(st.flags.ioSupplyUndervoltageFlag, ioSupplyUvDetect,
                                               st.bitLatching, statusRead);
        f.tempWarnFlag = latchFlag(st.flags.tempWarnFlag, next_st.liveTempWarn,
                                   st.bitLatching, statusRead);
        f.tempHighFlag = latchFlag(st.flags.tempHighFlag, next_st.liveTempHigh,
                                   st.bitLatching, statusRead);
        f.innerStarClampFlag = latchFlag(st.flags.innerStarClampFlag, next_st.liveTrxdClamp,
                                         st.bitLatching, statusRead);
        f.transmitEnableClampFlag = latchFlag(st.flags.transmitEnableClampFlag, next_st.liveTxenClamp,
                                              st.bitLatching, statusRead);
        f.innerStarCollisionFlag = collSet | (st.flags.innerStarCollisionFlag & ~statusRead);
        f.parity = 1'b0;
        f.parity = ~(^f);
        next_st.flags = f;

        // ======================================================================
        // Interrupt events: set wins over a same-cycle write-one clear.
        events.wakeInterrupt = localWakeEvent | innerStarWakeEvent;
        events.undervoltageInterrupt = |(uvNow & ~st.prevUv);
        events.tempInterrupt = (next_st.liveTempWarn & ~st.liveTempWarn) |
                               (next_st.liveTempHigh & ~st.liveTempHigh);
        events.clampInterrupt = (next_st.liveTrxdClamp & ~st.liveTrxdClamp) |
                                (next_st.liveTxenClamp & ~st.liveTxenClamp) | collSet;

        // ======================================================================
        // Register writes
        if (wrEn && (addr == `GSF_ADDR_CONFIG)) begin
            next_st.bitLatching = wdata[`GSF_CFG_LATCH_BIT];
            next_st.innerStarInput = wdata[`GSF_CFG_INPUT_BIT];
        end
        if (wrEn && (addr == `GSF_ADDR_IRQ_MASK)) begin
            next_st.irqMask = wdata[3:0];
        end
        if (wrEn && (addr == `GSF_ADDR_IRQ_STATUS)) begin
            next_st.irqStatus = events | (st.irqStatus & ~gsf_irq_t'(wdata[3:0]));
        end else begin
            next_st.irqStatus = events | st.irqStatus;
        end
        next_st.irq = |(next_st.irqStatus & next_st.irqMask);

        // ======================================================================
        // Read data stands for exactly the cycle after the strobe.
        next_st.rdata = 16'h0000;
        if (rdEn) begin
            case (addr)
                `GSF_ADDR_STATUS: next_st.rdata = {4'h0, st.flags};
                `GSF_ADDR_CONFIG: next_st.rdata = {14'h0000, st.innerStarInput, st.bitLatching};
                `GSF_ADDR_IRQ_STATUS: next_st.rdata = {12'h000, st.irqStatus};
                `GSF_ADDR_IRQ_MASK: next_st.rdata = {12'h000, st.irqMask};
                `GSF_ADDR_MODE: next_st.rdata = {14'h0000, st.digitalInputsDisabled, st.ctrl == CTRL_AUTONOMOUS};
                default: next_st.rdata = 16'h0000;
            endcase
        end

        // ======================================================================
        // Protective outputs
        next_st.innerStarDriverEnable = ~next_st.liveTempHigh & ~next_st.liveTrxdClamp;
        next_st.innerStarDataIgnore = next_st.liveTrxdClamp | ioSupplyUvDetect;
        next_st.transmitInputsIgnore = next_st.liveTxenClamp | ioSupplyUvDetect;
        next_st.forceBranchDisabled = next_st.liveTempHigh;
        next_st.digitalInputsDisabled = ioSupplyUvDetect;
    end

    // ==========================================================================
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
            st.bitLatching <= 1'(`GSF_CONFIG_RESET >> `GSF_CFG_LATCH_BIT);
            st.irqMask <= `GSF_IRQ_MASK_RESET;
            st.ctrl <= CTRL_HOST;
            st.prevMode <= STAR_NORMAL_MODE;
            st.flags.parity <= 1'b1;
            st.innerStarDriverEnable <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign irq = st.irq;
    assign innerStarDriverEnable = st.innerStarDriverEnable;
    assign innerStarDataIgnore = st.innerStarDataIgnore;
    assign transmitInputsIgnore = st.transmitInputsIgnore;
    assign forceBranchDisabled = st.forceBranchDisabled;
    assign digitalInputsDisabled = st.digitalInputsDisabled;
    assign autonomousModeFlag = (st.ctrl == CTRL_AUTONOMOUS);

endmodule

// ### testbench/gsf_status_properties.sv
// Purpose: Port-level assertions of the general status flag block.
// Assumes: One clock; srst is synchronous and active high.
// Notes: Outputs may lag their detector by up to two edges.
`timescale 1ns/1ps
module gsf_status_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic rd,
    input wire logic [15:0] rdata,
    input wire logic ioSupplyUvDetect,
    input wire logic tempHighDetect,
    input wire logic linkActivity,
    input wire logic innerStarLineA,
    input wire logic innerStarLineB,
    input wire logic controllerTransmitEnable,
    input wire logic innerStarDriverEnable,
    input wire logic innerStarDataIgnore,
    input wire logic transmitInputsIgnore,
    input wire logic forceBranchDisabled,
    input wire logic digitalInputsDisabled,
    input wire logic autonomousModeFlag
);
    // ==========================================================================
    // Hold-time counters
    // They saturate, so a line stuck for long never wraps below its threshold.
    logic [11:0] txLowCnt;
    logic [11:0] vioCnt;
    always_ff @(posedge clk) begin
        if (srst) begin
            txLowCnt <= 12'h000;
            vioCnt <= 12'h000;
        end else begin
            txLowCnt <= controllerTransmitEnable ? 12'h000 : txLowCnt + {11'h000, ~&txLowCnt};
            vioCnt <= ioSupplyUvDetect ? vioCnt + {11'h000, ~&vioCnt} : 12'h000;
        end
    end
    // ==========================================================================
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    a_refused_read: assert property (rd && ioSupplyUvDetect |=> rdata == 16'h0000)
        else $error("read answered during io undervoltage");
    a_inputs_off: assert property (ioSupplyUvDetect [*2] |=> digitalInputsDisabled && innerStarDataIgnore)
        else $error("inputs not disabled");
    a_auto_timeout: assert property (vioCnt >= 12'h9C8 |-> autonomousModeFlag)
        else $error("autonomous mode missing");
    a_hot_shutdown: assert property (tempHighDetect [*2] |=> forceBranchDisabled && !innerStarDriverEnable)
        else $error("high temperature not acted on");
    a_hot_hold: assert property (forceBranchDisabled && linkActivity && $past(linkActivity) |=> forceBranchDisabled)
        else $error("temperature released during activity");
    a_hot_release: assert property ((!tempHighDetect && !linkActivity) [*3] |=> !forceBranchDisabled)
        else $error("temperature not released");
    a_controller_transmit_enable_clamp: assert property (txLowCnt >= 12'h068 |-> transmitInputsIgnore)
        else $error("transmit clamp missing");
    a_controller_transmit_enable_free: assert property ((controllerTransmitEnable && !ioSupplyUvDetect) [*3] |=> !transmitInputsIgnore)
        else $error("transmit clamp stuck");
    a_link_free: assert property ((innerStarLineA && innerStarLineB && !ioSupplyUvDetect) [*3] |=> !innerStarDataIgnore)
        else $error("link clamp stuck");
    c_auto: cover property ($rose(autonomousModeFlag));
    c_controller_transmit_enable: cover property ($rose(transmitInputsIgnore));
    c_hot: cover property ($rose(forceBranchDisabled));
endmodule

bind gsf_general_status_flag_logic gsf_status_properties u_props (
    .clk, .srst, .rd, .rdata, .ioSupplyUvDetect, .tempHighDetect, .linkActivity, .innerStarLineA,
    .innerStarLineB, .controllerTransmitEnable, .innerStarDriverEnable, .innerStarDataIgnore,
    .transmitInputsIgnore, .forceBranchDisabled, .digitalInputsDisabled, .autonomousModeFlag
);

// ### testbench/gsf_host_model.sv
// Purpose: Host that reaches the status registers over the register port.
// Assumes: Read data stand only in the cycle after the read strobe.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/1ps
module gsf_host_model (
    input wire logic clk,
    input wire logic [15:0] rdata,
    output logic [7:0] addr,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd
);
    initial begin
        addr = 8'h00;
        wdata = 16'h0000;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic busWrite(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    task automatic busRead(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        d = rdata;
    endtask
endmodule

// ### testbench/general_status_flag_logic_tb_top.sv
// Purpose: Self-checking bench of the general status flag block.
// Assumes: Counts as set in gsf_defines.svh: clamp 100, collision 50, io timeout 2500 cycles.
// Notes: Idle levels keep transmit enable and both link lines high.
`timescale 1ns/1ps
`include "gsf_defines.svh"
module general_status_flag_logic_tb_top
    import gsf_pkg::*;
;
    logic clk;
    logic srst = 1'b1;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic wr, rd, irq, innerStarDriverEnable, innerStarDataIgnore, transmitInputsIgnore;
    logic forceBranchDisabled, digitalInputsDisabled, autonomousModeFlag;
    logic localWakeEvent = 1'b0, innerStarWakeEvent = 1'b0, guardianEnablePin = 1'b0, linkActivity = 1'b0;
    logic batteryUvDetect = 1'b0, coreSupplyUvDetect = 1'b0, ioSupplyUvDetect = 1'b0;
    logic tempWarnDetect = 1'b0, tempHighDetect = 1'b0;
    logic innerStarLineA = 1'b1, innerStarLineB = 1'b1, controllerTransmitEnable = 1'b1;
    gsf_mode_e starMode = STAR_NORMAL_MODE;
    int errorCnt = 0;
    int totalChecks = 0;
    int cycCnt = 0;
    gsf_general_status_flag_logic dut (.clk, .srst, .addr, .wdata, .wr, .rd, .rdata, .localWakeEvent,
        .innerStarWakeEvent, .guardianEnablePin, .batteryUvDetect, .coreSupplyUvDetect, .ioSupplyUvDetect,
        .tempWarnDetect, .tempHighDetect, .linkActivity, .innerStarLineA, .innerStarLineB,
        .controllerTransmitEnable, .starMode, .irq, .innerStarDriverEnable, .innerStarDataIgnore,
        .transmitInputsIgnore, .forceBranchDisabled, .digitalInputsDisabled, .autonomousModeFlag);
    gsf_host_model host (.clk, .rdata, .addr, .wdata, .wr, .rd);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // ==========================================================================
    // Helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic checkBit(input logic got, input logic exp);
        check({15'h0000, got}, {15'h0000, exp});
    endtask
    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chkRd(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.busRead(a, d);
        check(d, exp);
    endtask
    // The parity bit is appended here so every expected word has odd weight.
    task automatic chkStat(input logic [10:0] f);
        chkRd(`GSF_ADDR_STATUS, {4'h0, f, ~^f});
    endtask
    // ==========================================================================
    // Scenarios
    task automatic testWake();
        chkStat(11'h000);
        chkRd(8'h20, 16'h0000);
        @(posedge clk) localWakeEvent <= 1'b1;
        @(posedge clk) localWakeEvent <= 1'b0;
        waitCyc(1);
        checkBit(irq, 1'b0);
        chkRd(`GSF_ADDR_IRQ_STATUS, 16'h0001);
        host.busWrite(`GSF_ADDR_IRQ_MASK, 16'h000F);
        waitCyc(1);
        checkBit(irq, 1'b1);
        chkStat(11'h400);
        chkStat(11'h000);
        host.busWrite(`GSF_ADDR_IRQ_STATUS, 16'h0001);
        waitCyc(1);
        checkBit(irq, 1'b0);
        @(posedge clk) innerStarWakeEvent <= 1'b1;
        @(posedge clk) innerStarWakeEvent <= 1'b0;
        chkStat(11'h200);
        chkRd(`GSF_ADDR_IRQ_STATUS, 16'h0001);
        @(posedge clk) innerStarWakeEvent <= 1'b1;
        @(posedge clk) innerStarWakeEvent <= 1'b0;
        @(posedge clk) starMode <= STAR_STANDBY_MODE;
        waitCyc(2);
        chkStat(11'h000);
        @(posedge clk) starMode <= STAR_NORMAL_MODE;
        @(posedge clk) localWakeEvent <= 1'b1;
        @(posedge clk) localWakeEvent <= 1'b0;
        @(posedge clk) starMode <= STAR_SLEEP_MODE;
        waitCyc(2);
        chkStat(11'h000);
        @(posedge clk) starMode <= STAR_NORMAL_MODE;
        @(posedge clk) guardianEnablePin <= 1'b1;
        chkStat(11'h100);
        @(posedge clk) guardianEnablePin <= 1'b0;
        chkStat(11'h000);
    endtask
    task automatic testLatching();
        // The wake scenario leaves its interrupt pending; clear it so only the new event shows.
        host.busWrite(`GSF_ADDR_IRQ_STATUS, 16'h000F);
        host.busWrite(`GSF_ADDR_CONFIG, 16'h0001);
        chkRd(`GSF_ADDR_CONFIG, 16'h0001);
        @(posedge clk) batteryUvDetect <= 1'b1;
        @(posedge clk) batteryUvDetect <= 1'b0;
        waitCyc(2);
        chkRd(`GSF_ADDR_IRQ_STATUS, 16'h0002);
        chkStat(11'h080);
        chkStat(11'h000);
        host.busWrite(`GSF_ADDR_CONFIG, 16'h0000);
        @(posedge clk) coreSupplyUvDetect <= 1'b1;
        chkStat(11'h040);
        @(posedge clk) coreSupplyUvDetect <= 1'b0;
        chkStat(11'h000);
    endtask
    task automatic testClamps();
        @(posedge clk) controllerTransmitEnable <= 1'b0;
        waitCyc(110);
        checkBit(transmitInputsIgnore, 1'b1);
        chkStat(11'h002);
        @(posedge clk) controllerTransmitEnable <= 1'b1;
        waitCyc(3);
        checkBit(transmitInputsIgnore, 1'b0);
        chkStat(11'h000);
        host.busWrite(`GSF_ADDR_CONFIG, 16'h0002);
        host.busWrite(`GSF_ADDR_IRQ_STATUS, 16'h000F);
        @(posedge clk);
        innerStarLineA <= 1'b0;
        innerStarLineB <= 1'b0;
        waitCyc(110);
        checkBit(innerStarDataIgnore, 1'b1);
        checkBit(innerStarDriverEnable, 1'b0);
        checkBit(irq, 1'b1);
        chkRd(`GSF_ADDR_IRQ_STATUS, 16'h0008);
        @(posedge clk) innerStarLineB <= 1'b1;
        chkStat(11'h005);
        @(posedge clk) innerStarLineA <= 1'b1;
        chkStat(11'h000);
        checkBit(innerStarDataIgnore, 1'b0);
    endtask
    task automatic testTemperature();
        @(posedge clk) tempHighDetect <= 1'b1;
        waitCyc(3);
        checkBit(forceBranchDisabled, 1'b1);
        chkStat(11'h008);
        @(posedge clk);
        linkActivity <= 1'b1;
        tempHighDetect <= 1'b0;
        waitCyc(4);
        checkBit(forceBranchDisabled, 1'b1);
        @(posedge clk) linkActivity <= 1'b0;
        waitCyc(4);
        checkBit(forceBranchDisabled, 1'b0);
        @(posedge clk) tempWarnDetect <= 1'b1;
        chkStat(11'h010);
        @(posedge clk) tempWarnDetect <= 1'b0;
    endtask
    task automatic testIoSupply();
        @(posedge clk) ioSupplyUvDetect <= 1'b1;
        waitCyc(3);
        checkBit(digitalInputsDisabled, 1'b1);
        chkRd(`GSF_ADDR_STATUS, 16'h0000);
        waitCyc(2510);
        checkBit(autonomousModeFlag, 1'b1);
        @(posedge clk) ioSupplyUvDetect <= 1'b0;
        waitCyc(3);
        chkRd(`GSF_ADDR_MODE, 16'h0001);
        host.busWrite(`GSF_ADDR_MODE, 16'h0001);
        chkRd(`GSF_ADDR_MODE, 16'h0000);
        chkStat(11'h000);
    endtask
    // ==========================================================================
    // Run control
    task automatic endOfTest();
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycCnt <= cycCnt + 1;
        if (cycCnt == 10000) begin
            errorCnt++;
            endOfTest();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        testWake();
        testLatching();
        testClamps();
        testTemperature();
        testIoSupply();
        endOfTest();
    end
endmodule
